/* rtl/ddsl_pkg.sv */
// Constants and command layout of the dual DAC serial load front end.
// Assumes a 24-bit frame from a host that shifts data on the rising serial clock edge, so the falling edge samples settled data.
package ddsl_pkg;
	localparam int unsigned FRAME_BITS = 24;
	localparam int unsigned DATA_W = 16;
	localparam int unsigned CNT_W = 5;
	localparam int unsigned RD_POS = 23;
	localparam int unsigned CMD_HI = 22;
	localparam int unsigned CMD_LO = 20;
	localparam int unsigned ADDR_HI = 19;
	localparam int unsigned ADDR_LO = 16;
	localparam int unsigned GPIO_DIR_LO = 0;
	localparam int unsigned GPIO_OUT_LO = 2;
	localparam logic [2:0] CMD_DAC = 3'h0;
	localparam logic [2:0] CMD_GPIO = 3'h1;
	localparam logic [3:0] ADDR_A = 4'h0;
	localparam logic [3:0] ADDR_B = 4'h1;
	localparam logic [3:0] ADDR_ALL = 4'h4;
	localparam logic [15:0] DAC_RESET = 16'h0000;
	localparam logic [15:0] CLEAR_CODE = 16'h0000;
	localparam logic [1:0] GPIO_DIR_RESET = 2'h0;
	localparam logic [1:0] GPIO_OUT_RESET = 2'h0;
	localparam int unsigned FIFO_DEPTH = 8;
	typedef enum logic [2:0] {
		DDSL_IDLE = 3'b001,
		DDSL_WAIT_END = 3'b010,
		DDSL_PUSH = 3'b100
	} ddsl_state_t;
endpackage

/* rtl/ddsl_stream_if.sv */
// Valid/ready word stream between the frame collector, the FIFO and the apply stage.
// Assumes both ends sit on the same reference clock.
`timescale 1ns/100ps
`default_nettype none
interface ddsl_stream_if #(parameter int unsigned W = 24);
	logic valid;
	logic ready;
	logic [W-1:0] data;
	modport src(output valid, output data, input ready);
	modport snk(input valid, input data, output ready);
endinterface // ddsl_stream_if
`default_nettype wire

/* rtl/ddsl_fifo.sv */
// Synchronous word FIFO with valid/ready on both sides.
// Assumes one clock; depth must be a power of two of at least two.
`timescale 1ns/100ps
`default_nettype none
module ddsl_fifo import ddsl_pkg::*; #(
	parameter int unsigned W = 24,
	parameter int unsigned DEPTH = 8
) (
	input wire logic i_ref_clk,
	input wire logic i_rst_b,
	input wire logic i_ce,
	ddsl_stream_if.snk s_in,
	ddsl_stream_if.src s_out
);
	localparam int unsigned AW = $clog2(DEPTH);
	if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
		$error("ddsl_fifo: DEPTH must be a power of two of at least two");
	end
	logic [W-1:0] mem_q [DEPTH];
	logic [AW:0] wr_q, wr_d, rd_q, rd_d;
	logic push, pop;
	assign s_in.ready = (wr_q - rd_q) != (AW+1)'(DEPTH);
	assign s_out.valid = wr_q != rd_q;
	assign s_out.data = mem_q[rd_q[AW-1:0]];
	assign push = s_in.valid && s_in.ready;
	assign pop = s_out.valid && s_out.ready;
	always_comb begin
		wr_d = push ? wr_q + 1'b1 : wr_q;
		rd_d = pop ? rd_q + 1'b1 : rd_q;
	end
	always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			wr_q <= '0;
			rd_q <= '0;
		end else if (i_ce) begin
			wr_q <= wr_d;
			rd_q <= rd_d;
		end
	end
	// Storage has no reset; only words between the pointers are ever read
	always_ff @(posedge i_ref_clk) begin
		if (i_ce && push) begin
			mem_q[wr_q[AW-1:0]] <= s_in.data;
		end
	end
	a_fifo_no_overrun: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
		(wr_q - rd_q) <= (AW+1)'(DEPTH)) else $error("FIFO count above depth");
endmodule // ddsl_fifo
`default_nettype wire

/* rtl/ddsl_link.sv */
// Serial-clock side: shift register, bit counter, serial output.
// Assumes the serial clock stops outside frames; frame select is timed against it.
`timescale 1ns/100ps
`default_nettype none
module ddsl_link import ddsl_pkg::*; (
	input wire logic i_sclk,
	input wire logic i_rst_b,
	input wire logic i_sync_n,
	input wire logic i_serial_in,
	input wire logic i_rb_arm,
	input wire logic [FRAME_BITS-1:0] i_rb_word,
	output logic o_serial_out,
	output logic [FRAME_BITS-1:0] o_word,
	output logic o_word_tgl
);
	logic [CNT_W-1:0] cnt_q, cnt_d;
	logic [FRAME_BITS-1:0] shift_q, shift_d, word_d;
	logic tgl_d;
	always_comb begin
		cnt_d = (cnt_q == CNT_W'(FRAME_BITS)) ? cnt_q : cnt_q + 1'b1;
		shift_d = shift_q;
		word_d = o_word;
		tgl_d = o_word_tgl;
		if (!i_sync_n) begin
			// A pending readback word replaces the old contents at the frame's first edge
			if (cnt_q == '0 && i_rb_arm) begin
				shift_d = {i_rb_word[FRAME_BITS-2:0], i_serial_in};
			end else begin
				shift_d = {shift_q[FRAME_BITS-2:0], i_serial_in};
			end
			if (cnt_q == CNT_W'(FRAME_BITS-1)) begin
				word_d = shift_d;
				tgl_d = ~o_word_tgl;
			end
		end
	end
	// Frame select high clears the count, so a short frame never completes
	// Reset clears it too: the serial clock may never tick before the first frame
	always_ff @(negedge i_sclk or posedge i_sync_n or negedge i_rst_b) begin
		if (!i_rst_b) begin
			cnt_q <= '0;
		end else if (i_sync_n) begin
			cnt_q <= '0;
		end else begin
			cnt_q <= cnt_d;
		end
	end
	always_ff @(negedge i_sclk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			shift_q <= '0;
			o_word <= '0;
			o_word_tgl <= 1'b0;
		end else begin
			shift_q <= shift_d;
			o_word <= word_d;
			o_word_tgl <= tgl_d;
		end
	end
	always_ff @(posedge i_sclk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_serial_out <= 1'b0;
		end else begin
			o_serial_out <= shift_q[FRAME_BITS-1];
		end
	end
	a_word_on_24th: assert property (@(posedge i_sclk) disable iff (!i_rst_b)
		(cnt_q == CNT_W'(FRAME_BITS) && $past(cnt_q) == CNT_W'(FRAME_BITS-1))
		|-> (o_word_tgl != $past(o_word_tgl)))
		else $error("Word not handed over at 24th falling edge");
	a_sdo_follows: assert property (@(posedge i_sclk) disable iff (!i_rst_b)
		1'b1 |=> (o_serial_out == $past(shift_q[FRAME_BITS-1])))
		else $error("Serial output does not carry shift register MSB");
endmodule // ddsl_link
`default_nettype wire

/* rtl/ddsl_top.sv */
// Dual DAC serial load control: frame commit, DAC registers, load and clear, GPIO.
// Assumes a 25 MHz reference clock; pins arrive asynchronously and are synchronised here.
`timescale 1ns/100ps
`default_nettype none
module ddsl_top import ddsl_pkg::*; #(
	parameter int unsigned DEPTH = FIFO_DEPTH
) (
	input wire logic i_ref_clk,
	input wire logic i_rst_b,
	input wire logic i_ce,
	input wire logic i_sclk,
	input wire logic i_sync_n,
	input wire logic i_serial_in,
	output logic o_serial_out,
	input wire logic i_clear_edge_n,
	input wire logic i_output_load_n,
	input wire logic i_output_clamp_in_n,
	input wire logic i_supply_ok,
	output logic o_monitor_reset_out,
	input wire logic i_gpio_pin0,
	output logic o_gpio_pin0,
	output logic o_gpio_pin0_oe,
	output logic o_gpio_pin0_pullup,
	input wire logic i_gpio_pin1,
	output logic o_gpio_pin1,
	output logic o_gpio_pin1_oe,
	output logic o_gpio_pin1_pullup,
	output logic [DATA_W-1:0] o_dac_code_a,
	output logic [DATA_W-1:0] o_dac_code_b,
	output logic o_out_clamp
);
	localparam int unsigned NS = 8;
	// Synchroniser lanes
	localparam int unsigned S_TGL = 0;
	localparam int unsigned S_SYNC = 1;
	localparam int unsigned S_CLR = 2;
	localparam int unsigned S_LOAD = 3;
	localparam int unsigned S_CLAMP = 4;
	localparam int unsigned S_G0 = 5;
	localparam int unsigned S_G1 = 6;
	localparam int unsigned S_MON = 7;
	localparam logic [NS-1:0] SYNC_IDLE = {{(NS-1){1'b1}}, 1'b0};

	logic [FRAME_BITS-1:0] link_word, word_q, word_d, rb_q, rb_d;
	logic link_tgl, rb_arm_q, rb_arm_d;
	logic [NS-1:0] meta_q, sync_q, prev_q;
	logic tgl_edge, sync_high, clr_fall, load_fall;
	ddsl_state_t st_q, st_d;
	logic [DATA_W-1:0] in_q [2];
	logic [DATA_W-1:0] in_d [2];
	logic [DATA_W-1:0] dac_q [2];
	logic [DATA_W-1:0] dac_d [2];
	logic [1:0] pend_q, pend_d, hit;
	logic [1:0] dir_q, dir_d, out_q, out_d, pins;
	logic clamp_q, mon_q;
	logic apply, is_rd;
	logic [2:0] cmd;
	logic [DATA_W-1:0] data;

	ddsl_stream_if #(.W(FRAME_BITS)) wr_if();
	ddsl_stream_if #(.W(FRAME_BITS)) rd_if();

	ddsl_link u_link (
		.i_sclk(i_sclk),
		.i_rst_b(i_rst_b),
		.i_sync_n(i_sync_n),
		.i_serial_in(i_serial_in),
		.i_rb_arm(rb_arm_q),
		.i_rb_word(rb_q),
		.o_serial_out(o_serial_out),
		.o_word(link_word),
		.o_word_tgl(link_tgl)
	);

	ddsl_fifo #(.W(FRAME_BITS), .DEPTH(DEPTH)) u_fifo (
		.i_ref_clk(i_ref_clk),
		.i_rst_b(i_rst_b),
		.i_ce(i_ce),
		.s_in(wr_if.snk),
		.s_out(rd_if.src)
	);

	// Address decode used for both writes and readback
	function automatic logic [1:0] chan_hit(input logic [3:0] addr);
		chan_hit = {addr == ADDR_B || addr == ADDR_ALL, addr == ADDR_A || addr == ADDR_ALL};
	endfunction

	// Every pin level and the link toggle pass two flip-flops before use
	always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			meta_q <= SYNC_IDLE;
			sync_q <= SYNC_IDLE;
			prev_q <= SYNC_IDLE;
		end else if (i_ce) begin
			meta_q <= {i_supply_ok, i_gpio_pin1, i_gpio_pin0, i_output_clamp_in_n,
				i_output_load_n, i_clear_edge_n, i_sync_n, link_tgl};
			sync_q <= meta_q;
			prev_q <= sync_q;
		end
	end
	// Pins reset to their idle high level and the toggle lane low, as the link's toggle does,
	// so no false frame follows reset; a pin held low through reset gives one harmless edge
	assign tgl_edge = sync_q[S_TGL] != prev_q[S_TGL];
	assign sync_high = sync_q[S_SYNC];
	assign clr_fall = prev_q[S_CLR] && !sync_q[S_CLR];
	assign load_fall = prev_q[S_LOAD] && !sync_q[S_LOAD];
	assign pins = {sync_q[S_G1], sync_q[S_G0]};

	// Frame commit: a word is pushed only once its frame has ended with all bits
	always_comb begin
		st_d = st_q;
		word_d = word_q;
		wr_if.valid = 1'b0;
		wr_if.data = word_q;
		unique case (st_q)
			DDSL_IDLE: begin
				if (tgl_edge) begin
					word_d = link_word;
					st_d = DDSL_WAIT_END;
				end
			end
			DDSL_WAIT_END: begin
				if (sync_high) begin
					st_d = DDSL_PUSH;
				end
			end
			DDSL_PUSH: begin
				wr_if.valid = 1'b1;
				if (wr_if.ready) begin
					st_d = DDSL_IDLE;
				end
			end
			default: begin
				st_d = DDSL_IDLE;
			end
		endcase
	end
	always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			st_q <= DDSL_IDLE;
			word_q <= '0;
		end else if (i_ce) begin
			st_q <= st_d;
			word_q <= word_d;
		end
	end

	// Draining stalls for the clear cycle so a command never races the clear
	assign rd_if.ready = !clr_fall;
	assign apply = rd_if.valid && rd_if.ready;
	assign is_rd = rd_if.data[RD_POS];
	assign cmd = rd_if.data[CMD_HI:CMD_LO];
	assign data = rd_if.data[DATA_W-1:0];
	assign hit = chan_hit(rd_if.data[ADDR_HI:ADDR_LO]);

	// DAC and input registers, load and clear
	always_comb begin
		in_d = in_q;
		dac_d = dac_q;
		pend_d = pend_q;
		if (load_fall) begin
			for (int i = 0; i < 2; i++) begin
				if (pend_q[i]) begin
					dac_d[i] = in_q[i];
				end
			end
			pend_d = '0;
		end
		if (apply && !is_rd && cmd == CMD_DAC) begin
			for (int i = 0; i < 2; i++) begin
				if (hit[i]) begin
					in_d[i] = data;
					if (!sync_q[S_LOAD]) begin
						dac_d[i] = data;
					end else begin
						pend_d[i] = 1'b1;
					end
				end
			end
		end
		if (clr_fall) begin
			dac_d[0] = CLEAR_CODE;
			dac_d[1] = CLEAR_CODE;
		end
	end
	always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			in_q[0] <= DAC_RESET;
			in_q[1] <= DAC_RESET;
			dac_q[0] <= DAC_RESET;
			dac_q[1] <= DAC_RESET;
			pend_q <= '0;
		end else if (i_ce) begin
			in_q <= in_d;
			dac_q <= dac_d;
			pend_q <= pend_d;
		end
	end

	// GPIO configuration and readback word for the next frame
	always_comb begin
		dir_d = dir_q;
		out_d = out_q;
		rb_d = rb_q;
		rb_arm_d = rb_arm_q;
		if (tgl_edge) begin
			rb_arm_d = 1'b0;
		end
		if (apply && cmd == CMD_GPIO && !is_rd) begin
			dir_d = data[GPIO_DIR_LO +: 2];
			out_d = data[GPIO_OUT_LO +: 2];
		end
		if (apply && is_rd) begin
			rb_arm_d = 1'b1;
			if (cmd == CMD_GPIO) begin
				rb_d = {8'h00, 12'h000, out_q, pins};
			end else begin
				rb_d = {8'h00, hit[1] && !hit[0] ? in_q[1] : in_q[0]};
			end
		end
	end
	always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			dir_q <= GPIO_DIR_RESET;
			out_q <= GPIO_OUT_RESET;
			rb_q <= '0;
			rb_arm_q <= 1'b0;
			clamp_q <= 1'b1;
			mon_q <= 1'b1;
		end else if (i_ce) begin
			dir_q <= dir_d;
			out_q <= out_d;
			rb_q <= rb_d;
			rb_arm_q <= rb_arm_d;
			clamp_q <= !sync_q[S_CLAMP];
			mon_q <= !sync_q[S_MON];
		end
	end

	assign o_dac_code_a = dac_q[0];
	assign o_dac_code_b = dac_q[1];
	// Clamp only gates the outputs; the codes above stay untouched
	assign o_out_clamp = clamp_q;
	assign o_monitor_reset_out = mon_q;
	assign o_gpio_pin0 = out_q[0];
	assign o_gpio_pin1 = out_q[1];
	assign o_gpio_pin0_oe = dir_q[0];
	assign o_gpio_pin1_oe = dir_q[1];
	// The pull-up is a pad feature; the enable tells the pad when an input may float high
	assign o_gpio_pin0_pullup = !dir_q[0];
	assign o_gpio_pin1_pullup = !dir_q[1];

	a_clear_zeros: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
		(i_ce && clr_fall) |=> (dac_q[0] == CLEAR_CODE && dac_q[1] == CLEAR_CODE))
		else $error("Clear edge did not zero the DAC registers");
	a_direct_update: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
		(i_ce && apply && !is_rd && cmd == CMD_DAC && hit[0] && !sync_q[S_LOAD])
		|=> (dac_q[0] == $past(data)))
		else $error("Write with load low did not reach DAC register");
	a_held_update: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
		(i_ce && apply && !is_rd && cmd == CMD_DAC && hit[0] && sync_q[S_LOAD] && !load_fall)
		|=> ($stable(dac_q[0]) && pend_q[0] && in_q[0] == $past(data)))
		else $error("Write with load high changed the DAC register");
	a_load_transfer: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
		(i_ce && load_fall && !clr_fall && pend_q == 2'h3 && !apply)
		|=> (dac_q[0] == $past(in_q[0]) && dac_q[1] == $past(in_q[1]) && pend_q == '0))
		else $error("Load edge did not transfer both pending channels");
	a_partial_drop: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
		(i_ce && st_q == DDSL_IDLE && !tgl_edge) |=> !wr_if.valid[*2])
		else $error("Word pushed without a completed frame");
	a_frame_commit: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
		(i_ce && st_q == DDSL_WAIT_END && sync_high) |=> (st_q == DDSL_PUSH && wr_if.valid))
		else $error("Completed frame not committed after frame end");
	a_gpio_config: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
		(i_ce && apply && !is_rd && cmd == CMD_GPIO)
		|=> ({o_gpio_pin1_oe, o_gpio_pin0_oe} == $past(data[GPIO_DIR_LO +: 2])))
		else $error("GPIO direction not taken from command");
	a_pullup_input: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
		o_gpio_pin0_pullup != o_gpio_pin0_oe && o_gpio_pin1_pullup != o_gpio_pin1_oe)
		else $error("Pull-up enable disagrees with pin direction");
	a_clamp_keeps: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
		(i_ce && !sync_q[S_CLAMP] && !clr_fall && !apply && !load_fall)
		|=> (o_out_clamp && $stable(dac_q[0]) && $stable(dac_q[1])))
		else $error("Clamp did not assert or disturbed the registers");
	a_monitor_out: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
		(i_ce && !sync_q[S_MON]) |=> o_monitor_reset_out)
		else $error("Monitor reset output missed supply fault");
	a_direct_update_b: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
		(i_ce && apply && !is_rd && cmd == CMD_DAC && hit[1] && !sync_q[S_LOAD])
		|=> (dac_q[1] == $past(data)))
		else $error("Write with load low did not reach DAC register B");
	a_commit_capture: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
		(i_ce && st_q == DDSL_IDLE && tgl_edge) |=> (st_q == DDSL_WAIT_END && word_q == $past(link_word)))
		else $error("Completed word not captured from the link");
	a_readback_word: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
		(i_ce && apply && is_rd && cmd == CMD_GPIO) |=> (rb_arm_q && rb_q[3:0] == {$past(out_q), $past(pins)}))
		else $error("GPIO readback word not prepared");
	a_clamp_release: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
		(i_ce && sync_q[S_CLAMP]) |=> !o_out_clamp)
		else $error("Clamp output stayed on with the clamp input high");
	a_monitor_release: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
		(i_ce && sync_q[S_MON]) |=> !o_monitor_reset_out)
		else $error("Monitor reset output stayed on with the supply good");
endmodule // ddsl_top
`default_nettype wire

/* tb/ddsl_host_model.sv */
// Host serial port model: frame select, serial clock and data toward the DAC front end.
// Assumes the bench calls frame() one frame at a time; the serial clock idles high between frames.
`timescale 1ns/100ps
`default_nettype none
module ddsl_host_model (
	output logic o_sclk,
	output logic o_sync_n,
	output logic o_serial_in,
	input wire logic i_serial_out,
	output logic [22:0] o_rb_bits
);
	localparam int HALF = 16;
	initial begin
		o_sclk = 1'b1;
		o_sync_n = 1'b1;
		o_serial_in = 1'b0;
		o_rb_bits = '0;
	end
	// Sends MSB first; drop_last ends the frame one bit early
	task automatic frame(input logic [23:0] w, input logic drop_last);
		int n;
		n = drop_last ? 23 : 24;
		o_sync_n <= 1'b0;
		#HALF;
		for (int i = 0; i < n; i++) begin
			o_serial_in <= w[23-i];
			#HALF;
			o_sclk <= 1'b0;
			// Output moved on the previous rise, so it is settled here
			if (i > 0) o_rb_bits <= {o_rb_bits[21:0], i_serial_out};
			#HALF;
			o_sclk <= 1'b1;
		end
		#HALF;
		o_sync_n <= 1'b1;
		// Released data line must not keep its last value
		o_serial_in <= ~o_serial_in;
		#300;
	endtask
endmodule // ddsl_host_model
`default_nettype wire

/* tb/test_dual_dac_serial_load_control.sv */
// Self-checking bench for the dual DAC serial load front end.
// Assumes the host model drives the link; pins and GPIO pads are resolved here.
`timescale 1ns/100ps
`default_nettype none
module test_dual_dac_serial_load_control import ddsl_pkg::*;;
	logic ref_clk, rst_b, ce, clear_n, load_n, clamp_n, supply_ok;
	logic sclk, sync_n, serial_in, serial_out, monitor, out_clamp;
	logic g0_out, g0_oe, g0_pu, g1_out, g1_oe, g1_pu;
	logic [15:0] code_a, code_b;
	logic [22:0] rb_bits;
	int miscompares = 0;
	int checks_done = 0;
	wire logic gpio0 = g0_oe ? g0_out : (g0_pu ? 1'b1 : 1'bz);
	wire logic gpio1 = g1_oe ? g1_out : (g1_pu ? 1'b1 : 1'bz);

	ddsl_host_model ddsl_host_model_inst (.o_sclk(sclk), .o_sync_n(sync_n), .o_serial_in(serial_in),
		.i_serial_out(serial_out), .o_rb_bits(rb_bits));
	ddsl_top #(.DEPTH(8)) ddsl_top_inst (.i_ref_clk(ref_clk), .i_rst_b(rst_b), .i_ce(ce), .i_sclk(sclk),
		.i_sync_n(sync_n), .i_serial_in(serial_in), .o_serial_out(serial_out), .i_clear_edge_n(clear_n),
		.i_output_load_n(load_n), .i_output_clamp_in_n(clamp_n), .i_supply_ok(supply_ok),
		.o_monitor_reset_out(monitor), .i_gpio_pin0(gpio0), .o_gpio_pin0(g0_out), .o_gpio_pin0_oe(g0_oe),
		.o_gpio_pin0_pullup(g0_pu), .i_gpio_pin1(gpio1), .o_gpio_pin1(g1_out), .o_gpio_pin1_oe(g1_oe),
		.o_gpio_pin1_pullup(g1_pu), .o_dac_code_a(code_a), .o_dac_code_b(code_b), .o_out_clamp(out_clamp));

	initial begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Lets the edge's updates land before anything is sampled
	task automatic wait_cyc(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask

	task automatic complete_run();
		$display("checks %0d, mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic t_reset();
		wait_cyc(5);
		chk(code_a, 16'h0000);
		chk({14'h0, g0_oe, g1_oe}, 16'h0000);
		chk({14'h0, g0_pu, g1_pu}, 16'h0003);
		chk({14'h0, out_clamp, monitor}, 16'h0000);
	endtask

	task automatic t_direct();
		ddsl_host_model_inst.frame({1'b0, CMD_DAC, ADDR_A, 16'h1234}, 1'b0);
		wait_cyc(10);
		chk(code_a, 16'h1234);
		ddsl_host_model_inst.frame({1'b0, CMD_DAC, ADDR_B, 16'h8001}, 1'b0);
		wait_cyc(10);
		chk(code_b, 16'h8001);
		ddsl_host_model_inst.frame({1'b0, CMD_DAC, ADDR_ALL, 16'h00ff}, 1'b0);
		wait_cyc(10);
		chk(code_a, 16'h00ff);
		chk(code_b, 16'h00ff);
	endtask

	task automatic t_short();
		ddsl_host_model_inst.frame({1'b0, CMD_DAC, ADDR_A, 16'hffff}, 1'b1);
		wait_cyc(10);
		chk(code_a, 16'h00ff);
	endtask

	task automatic t_defer();
		@(posedge ref_clk) load_n <= 1'b1;
		wait_cyc(4);
		ddsl_host_model_inst.frame({1'b0, CMD_DAC, ADDR_A, 16'h5555}, 1'b0);
		ddsl_host_model_inst.frame({1'b0, CMD_DAC, ADDR_B, 16'haaaa}, 1'b0);
		wait_cyc(10);
		chk(code_a, 16'h00ff);
		chk(code_b, 16'h00ff);
		@(posedge ref_clk) load_n <= 1'b0;
		wait_cyc(5);
		chk(code_a, 16'h5555);
		chk(code_b, 16'haaaa);
	endtask

	task automatic t_clamp_monitor();
		// Clock enable low freezes the pin path, so the clamp must wait for it
		@(posedge ref_clk) ce <= 1'b0;
		clamp_n <= 1'b0;
		wait_cyc(4);
		chk({15'h0, out_clamp}, 16'h0000);
		@(posedge ref_clk) ce <= 1'b1;
		wait_cyc(4);
		chk({15'h0, out_clamp}, 16'h0001);
		chk(code_a, 16'h5555);
		@(posedge ref_clk) clamp_n <= 1'b1;
		supply_ok <= 1'b0;
		wait_cyc(4);
		chk({14'h0, out_clamp, monitor}, 16'h0001);
		@(posedge ref_clk) supply_ok <= 1'b1;
		wait_cyc(4);
		chk({15'h0, monitor}, 16'h0000);
	endtask

	task automatic t_clear();
		@(posedge ref_clk) clear_n <= 1'b0;
		wait_cyc(5);
		chk(code_a, 16'h0000);
		chk(code_b, 16'h0000);
		@(posedge ref_clk) clear_n <= 1'b1;
		wait_cyc(4);
	endtask

	task automatic t_gpio();
		// Pin 0 drives high, pin 1 stays input and is pulled up
		ddsl_host_model_inst.frame({1'b0, CMD_GPIO, 4'h0, 16'h0005}, 1'b0);
		wait_cyc(10);
		chk({14'h0, g0_oe, g0_out}, 16'h0003);
		chk({13'h0, g1_out, g1_oe, g1_pu}, 16'h0001);
		ddsl_host_model_inst.frame({1'b1, CMD_GPIO, 4'h0, 16'h0000}, 1'b0);
		ddsl_host_model_inst.frame({1'b1, CMD_GPIO, 4'h0, 16'h0000}, 1'b0);
		chk({12'h0, rb_bits[3:0]}, 16'h0007);
	endtask

	initial begin
		#200000;
		miscompares++;
		$display("mismatch at %0t: run did not finish in time", $time);
		complete_run();
	end

	initial begin
		// Reset falls after time zero so the link flops, whose clock is still idle, see the edge
		rst_b = 1'b1;
		ce = 1'b1;
		clear_n = 1'b1;
		load_n = 1'b0;
		clamp_n = 1'b1;
		supply_ok = 1'b1;
		#1;
		rst_b = 1'b0;
		repeat (20) @(posedge ref_clk);
		rst_b <= 1'b1;
		t_reset();
		t_direct();
		t_short();
		t_defer();
		t_clamp_monitor();
		t_clear();
		t_gpio();
		complete_run();
	end
endmodule // test_dual_dac_serial_load_control
`default_nettype wire
